/* File: src/cpsa_cpu_state.sv */
/*
 * Programmer-visible processor state: accumulators, program counter,
 * status flags, hardware stack, effective address former.
 * Assumes a register port master that never overlaps read and write
 * strobes and holds each strobe one cycle.
 */
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module cpsa_cpu_state (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [cpsa_pkg::CPSA_AW-1:0] reg_addr,
  input wire logic [cpsa_pkg::CPSA_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [cpsa_pkg::CPSA_DW-1:0] reg_rdata,
  // Peripheral data path through accumulator zero
  input wire logic [cpsa_pkg::CPSA_DW-1:0] periph_din,
  input wire logic periph_load,
  output logic [cpsa_pkg::CPSA_DW-1:0] periph_dout,
  // Flag state seen by the rest of the processor
  output logic [cpsa_pkg::CPSA_IEN_W-1:0] interrupt_enable_bits
);
  import cpsa_pkg::*;

  // Sum with carry out, shared by the accumulator adders
  function automatic logic [16:0] add_ext(input logic [15:0] a,
                                          input logic [15:0] b,
                                          input logic cin);
    add_ext = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
  endfunction : add_ext

  // Signed overflow: equal operand signs, different result sign
  function automatic logic ovf(input logic [15:0] a,
                               input logic [15:0] b,
                               input logic [15:0] r);
    ovf = (a[15] == b[15]) && (r[15] != a[15]);
  endfunction : ovf

  // Architectural state
  logic [15:0] acc_r [4];       // Working registers
  logic [15:0] pc_r;            // Next instruction address
  logic [15:0] flags_r;         // Status flag word
  logic [15:0] instr_r;         // Instruction for address forming
  logic test_r;                 // Last flag test result
  logic [15:0] rdata_r;         // Read data register

  // Decoded strobes
  logic wr_ac, wr_pc, wr_flags, wr_stack, wr_cmd, wr_instr;
  logic rd_stack;
  logic [1:0] ac_sel;
  logic [3:0] op;
  logic [3:0] flg_idx;
  logic [1:0] dr, sr, dr_lo, sr_lo;

  // Stack and address former links
  logic push, pull;
  logic [15:0] push_din, stack_top, stack_bottom;
  logic [15:0] ea;

  // Arithmetic results
  logic [15:0] op_a, op_b;
  logic [16:0] sum_add, sum_sub, sum_dlo, sum_dhi;
  logic alu_cy, alu_ov, alu_op;

  // Address decode
  assign ac_sel = reg_addr[3:2];
  assign wr_ac = reg_wr && ((reg_addr & CPSA_AC_MASK) == CPSA_OFF_ACC0);
  assign wr_pc = reg_wr && (reg_addr == CPSA_OFF_PC);
  assign wr_flags = reg_wr && (reg_addr == CPSA_OFF_FLAGS);
  assign wr_stack = reg_wr && (reg_addr == CPSA_OFF_STACK);
  assign wr_cmd = reg_wr && (reg_addr == CPSA_OFF_CMD);
  assign wr_instr = reg_wr && (reg_addr == CPSA_OFF_INSTR);
  assign rd_stack = reg_rd && (reg_addr == CPSA_OFF_STACK);

  // Command fields, NOP unless the command register is written
  assign op = wr_cmd ? reg_wdata[CPSA_CMD_OP_LO+:4] : CPSA_OP_NOP;
  assign flg_idx = reg_wdata[CPSA_CMD_IDX_LO+:4];
  assign dr = reg_wdata[CPSA_CMD_DR_LO+:2];
  assign sr = reg_wdata[CPSA_CMD_SR_LO+:2];
  // Low half of a double lives in the next register
  assign dr_lo = 2'(dr + 2'h1);
  assign sr_lo = 2'(sr + 2'h1);

  // Twos-complement operands, bit 15 is the sign
  assign op_a = acc_r[dr];
  assign op_b = acc_r[sr];
  assign sum_add = add_ext(op_a, op_b, 1'b0);
  assign sum_sub = add_ext(op_a, ~op_b, 1'b1);
  // Low halves first, carry into the high halves
  assign sum_dlo = add_ext(acc_r[dr_lo], acc_r[sr_lo], 1'b0);
  assign sum_dhi = add_ext(op_a, op_b, sum_dlo[16]);

  // Carry and excess for the current operation
  always_comb begin
    alu_cy = 1'b0;
    alu_ov = 1'b0;
    alu_op = 1'b1;
    unique case (op)
      CPSA_OP_ADD: begin
        alu_cy = sum_add[16];
        alu_ov = ovf(op_a, op_b, sum_add[15:0]);
      end
      CPSA_OP_SUB: begin
        alu_cy = sum_sub[16];
        alu_ov = ovf(op_a, ~op_b, sum_sub[15:0]);
      end
      CPSA_OP_DADD: begin
        alu_cy = sum_dhi[16];
        alu_ov = ovf(op_a, op_b, sum_dhi[15:0]);
      end
      CPSA_OP_DIV_CHK: begin
        // Quotient may be negative when signs differ
        alu_ov = op_a[15] ^ op_b[15];
      end
      default: begin
        alu_op = 1'b0;
      end
    endcase
  end

  // Stack feeds: data word, counter or flag word
  assign push = wr_stack || (op == CPSA_OP_PUSH_PC) || (op == CPSA_OP_PUSH_FLG);
  assign pull = rd_stack || (op == CPSA_OP_PULL_PC) || (op == CPSA_OP_PULL_FLG);
  assign push_din = (op == CPSA_OP_PUSH_PC) ? pc_r :
                    (op == CPSA_OP_PUSH_FLG) ? flags_r : reg_wdata;

  cpsa_stack #(
    .DEPTH(CPSA_STACK_DEPTH),
    .DW(CPSA_DW)
  ) u_stack (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .push(push),
    .pull(pull),
    .din(push_din),
    .top(stack_top),
    .bottom(stack_bottom)
  );

  cpsa_ea u_ea (
    .instr(instr_r),
    .pc(pc_r),
    .acc_two(acc_r[2]),
    .acc_three(acc_r[3]),
    .ea(ea)
  );

  // Accumulators: port writes, peripheral load, arithmetic results
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 4; i++) begin
        acc_r[i] <= CPSA_RST_WORD;
      end
    end else if (wr_ac) begin
      // Any of the four by address
      acc_r[ac_sel] <= reg_wdata;
    end else if (periph_load) begin
      // Peripheral data enters only accumulator zero
      acc_r[0] <= periph_din;
    end else if (op == CPSA_OP_ADD) begin
      acc_r[dr] <= sum_add[15:0];
    end else if (op == CPSA_OP_SUB) begin
      acc_r[dr] <= sum_sub[15:0];
    end else if (op == CPSA_OP_DADD) begin
      // High half in the first register, low in the next
      acc_r[dr] <= sum_dhi[15:0];
      acc_r[dr_lo] <= sum_dlo[15:0];
    end
  end

  // Program counter sequencing
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_r <= CPSA_RST_WORD;
    end else if (wr_pc) begin
      pc_r <= reg_wdata; // Branch target load
    end else if (op == CPSA_OP_SKIP || op == CPSA_OP_ADVANCE) begin
      pc_r <= 16'(pc_r + CPSA_PC_STEP);
    end else if (op == CPSA_OP_JUMP_EA) begin
      pc_r <= ea;
    end else if (op == CPSA_OP_PULL_PC) begin
      pc_r <= stack_top;
    end
  end

  // Status flags: restore, single-bit edits, arithmetic results
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_r <= CPSA_RST_WORD;
    end else if (wr_flags) begin
      flags_r <= reg_wdata;
    end else if (op == CPSA_OP_PULL_FLG) begin
      flags_r <= stack_top; // Restore from stack
    end else if (op == CPSA_OP_FLG_SET) begin
      flags_r[flg_idx] <= 1'b1;
    end else if (op == CPSA_OP_FLG_CLR) begin
      flags_r[flg_idx] <= 1'b0;
    end else if (alu_op) begin
      // Carry and excess sit below the link bit
      if (op != CPSA_OP_DIV_CHK) begin
        flags_r[CPSA_FLG_CARRY] <= alu_cy;
      end
      flags_r[CPSA_FLG_EXCESS] <= alu_ov;
    end
  end

  // Single flag test result
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      test_r <= 1'b0;
    end else if (op == CPSA_OP_FLG_TEST) begin
      test_r <= flags_r[flg_idx];
    end
  end

  // Instruction word held for address forming
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      instr_r <= CPSA_RST_WORD;
    end else if (wr_instr) begin
      instr_r <= reg_wdata;
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= CPSA_RST_WORD;
    end else if (!reg_rd) begin
      rdata_r <= CPSA_RST_WORD;
    end else if ((reg_addr & CPSA_AC_MASK) == CPSA_OFF_ACC0) begin
      rdata_r <= acc_r[ac_sel];
    end else begin
      unique case (reg_addr)
        CPSA_OFF_PC: rdata_r <= pc_r;
        CPSA_OFF_FLAGS: rdata_r <= flags_r;
        CPSA_OFF_STACK: rdata_r <= stack_top;
        CPSA_OFF_INSTR: rdata_r <= instr_r;
        CPSA_OFF_EA: rdata_r <= ea;
        CPSA_OFF_STATUS: rdata_r <= {15'h0000, test_r};
        // Unmapped offsets read as zero
        default: rdata_r <= CPSA_RST_WORD;
      endcase
    end
  end

  assign reg_rdata = rdata_r;
  assign periph_dout = acc_r[0];
  assign interrupt_enable_bits = flags_r[CPSA_FLG_IEN_LO+:CPSA_IEN_W];

  // Checks on stack, counter, flags and address forming
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  chk_push_top: assert property (
    wr_stack |=> stack_top == $past(reg_wdata))
    else $error("push did not place word on top");
  chk_pull_fill: assert property (
    pull && !push |=> stack_bottom == CPSA_RST_WORD)
    else $error("pull did not zero the bottom");
  chk_pull_data: assert property (
    rd_stack ##1 1'b1 |-> reg_rdata == $past(stack_top))
    else $error("pull data differs from old top");
  chk_skip_step: assert property (
    op == CPSA_OP_SKIP |=> pc_r == 16'($past(pc_r) + CPSA_PC_STEP))
    else $error("skip did not add one");
  chk_branch_load: assert property (
    op == CPSA_OP_JUMP_EA |=> pc_r == $past(ea))
    else $error("branch target not loaded");
  chk_flag_set: assert property (
    op == CPSA_OP_FLG_SET |=> flags_r[$past(flg_idx)])
    else $error("flag not set");
  chk_add_carry: assert property (
    op == CPSA_OP_ADD && !wr_flags |=> flags_r[CPSA_FLG_CARRY] == $past(sum_add[16]))
    else $error("carry flag wrong after add");
  chk_add_excess: assert property (
    op == CPSA_OP_ADD && op_a[15] == op_b[15] && sum_add[15] != op_a[15]
    |=> flags_r[CPSA_FLG_EXCESS])
    else $error("excess flag not set on overflow");
  chk_base_page: assert property (
    instr_r[CPSA_MODE_LO+1:CPSA_MODE_LO] == CPSA_MODE_BASE |-> ea[15:8] == 8'h00)
    else $error("base page address high byte not zero");
  chk_pcrel_ea: assert property (
    wr_instr && reg_wdata[CPSA_MODE_LO+1:CPSA_MODE_LO] == CPSA_MODE_PCREL
    ##1 !wr_pc && op != CPSA_OP_SKIP |->
    ea == 16'(pc_r + {{8{instr_r[CPSA_DISP_MSB]}}, instr_r[7:0]}))
    else $error("relative address not from counter");

  // Reload and restore paths, single flag clear
  chk_pull_pc: assert property (
    op == CPSA_OP_PULL_PC |=> pc_r == $past(stack_top))
    else $error("counter not reloaded from stack");
  chk_flag_restore: assert property (
    op == CPSA_OP_PULL_FLG |=> flags_r == $past(stack_top))
    else $error("flags not restored from stack");
  chk_flag_clear: assert property (
    op == CPSA_OP_FLG_CLR |=> !flags_r[$past(flg_idx)])
    else $error("flag not cleared");

  // Division check: excess from operand signs, carry left alone
  chk_div_excess: assert property (
    op == CPSA_OP_DIV_CHK |=> flags_r[CPSA_FLG_EXCESS] == $past(op_a[15] ^ op_b[15]))
    else $error("excess flag wrong after division check");
  chk_div_carry: assert property (
    op == CPSA_OP_DIV_CHK |=> $stable(flags_r[CPSA_FLG_CARRY]))
    else $error("division check changed carry");

  // Double-word low half, peripheral load, indexed address, read idle
  chk_dadd_low: assert property (
    op == CPSA_OP_DADD && !periph_load |=>
    acc_r[$past(dr_lo)] == 16'($past(acc_r[dr_lo]) + $past(acc_r[sr_lo])))
    else $error("double add low half wrong");
  chk_periph_load: assert property (
    periph_load && !wr_ac |=> acc_r[0] == $past(periph_din))
    else $error("peripheral word not in accumulator zero");
  chk_idx2_ea: assert property (
    instr_r[CPSA_MODE_LO+1:CPSA_MODE_LO] == CPSA_MODE_IDX2 |->
    ea == 16'(acc_r[2] + {{8{instr_r[CPSA_DISP_MSB]}}, instr_r[7:0]}))
    else $error("indexed address not from accumulator two");
  chk_read_idle: assert property (
    !reg_rd |=> reg_rdata == CPSA_RST_WORD)
    else $error("read data stood past its cycle");

  // Main scenarios: full stack push, pull, excess, relative mode, negative quotient
  cov_push_full: cover property (wr_stack && stack_bottom != CPSA_RST_WORD);
  cov_pull_data: cover property (rd_stack ##1 reg_rdata != CPSA_RST_WORD);
  cov_add_excess: cover property (op == CPSA_OP_ADD ##1 flags_r[CPSA_FLG_EXCESS]);
  cov_pcrel_mode: cover property (
    wr_instr && reg_wdata[CPSA_MODE_LO+1:CPSA_MODE_LO] == CPSA_MODE_PCREL);
  cov_div_negative: cover property (op == CPSA_OP_DIV_CHK && op_a[15] != op_b[15]);
endmodule : cpsa_cpu_state

/* File: src/cpsa_pkg.sv */
/*
 * Shared constants for the processor state block: register offsets,
 * command codes, instruction and flag field positions, reset values.
 * Assumes a byte-addressed register port with 8 address bits.
 */
package cpsa_pkg;
  // Data and port widths
  localparam int CPSA_DW = 16;
  localparam int CPSA_AW = 8;
  localparam int CPSA_STACK_DEPTH = 16;

  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] CPSA_OFF_ACC0 = 8'h00;
  localparam logic [7:0] CPSA_AC_MASK = 8'hF3;
  localparam logic [7:0] CPSA_OFF_PC = 8'h10;
  localparam logic [7:0] CPSA_OFF_FLAGS = 8'h14;
  localparam logic [7:0] CPSA_OFF_STACK = 8'h18;
  localparam logic [7:0] CPSA_OFF_CMD = 8'h1C;
  localparam logic [7:0] CPSA_OFF_INSTR = 8'h20;
  localparam logic [7:0] CPSA_OFF_EA = 8'h24;
  localparam logic [7:0] CPSA_OFF_STATUS = 8'h28;

  // Command codes in the command register
  localparam logic [3:0] CPSA_OP_NOP = 4'h0;
  localparam logic [3:0] CPSA_OP_SKIP = 4'h1;
  localparam logic [3:0] CPSA_OP_ADVANCE = 4'h2;
  localparam logic [3:0] CPSA_OP_JUMP_EA = 4'h3;
  localparam logic [3:0] CPSA_OP_PUSH_PC = 4'h4;
  localparam logic [3:0] CPSA_OP_PULL_PC = 4'h5;
  localparam logic [3:0] CPSA_OP_PUSH_FLG = 4'h6;
  localparam logic [3:0] CPSA_OP_PULL_FLG = 4'h7;
  localparam logic [3:0] CPSA_OP_FLG_SET = 4'h8;
  localparam logic [3:0] CPSA_OP_FLG_CLR = 4'h9;
  localparam logic [3:0] CPSA_OP_FLG_TEST = 4'hA;
  localparam logic [3:0] CPSA_OP_ADD = 4'hB;
  localparam logic [3:0] CPSA_OP_SUB = 4'hC;
  localparam logic [3:0] CPSA_OP_DADD = 4'hD;
  localparam logic [3:0] CPSA_OP_DIV_CHK = 4'hE;

  // Command word fields
  localparam int CPSA_CMD_OP_LO = 0;
  localparam int CPSA_CMD_IDX_LO = 4;
  localparam int CPSA_CMD_DR_LO = 8;
  localparam int CPSA_CMD_SR_LO = 10;

  // Instruction word fields
  localparam int CPSA_MODE_LO = 8;
  localparam int CPSA_DISP_MSB = 7;
  localparam logic [1:0] CPSA_MODE_BASE = 2'h0;
  localparam logic [1:0] CPSA_MODE_PCREL = 2'h1;
  localparam logic [1:0] CPSA_MODE_IDX2 = 2'h2;
  localparam logic [1:0] CPSA_MODE_IDX3 = 2'h3;

  // Flag word layout
  localparam int CPSA_FLG_LINK = 15;
  localparam int CPSA_FLG_CARRY = 14;
  localparam int CPSA_FLG_EXCESS = 13;
  localparam int CPSA_FLG_IEN_LO = 0;
  localparam int CPSA_IEN_W = 4;

  // Reset value and counter step
  localparam logic [15:0] CPSA_RST_WORD = 16'h0000;
  localparam logic [15:0] CPSA_PC_STEP = 16'h0001;
endpackage : cpsa_pkg

/* File: src/cpsa_stack.sv */
/*
 * Last-in/first-out word stack pushed and pulled only at its top, bottom entry also output.
 * Assumes push and pull are never asserted in the same cycle.
 */
`timescale 1ns/10ps
module cpsa_stack #(
  parameter int DEPTH = cpsa_pkg::CPSA_STACK_DEPTH,
  parameter int DW = cpsa_pkg::CPSA_DW
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Stack operations
  input wire logic push,
  input wire logic pull,
  input wire logic [DW-1:0] din,
  // Current top and bottom entries
  output logic [DW-1:0] top,
  output logic [DW-1:0] bottom
);
  import cpsa_pkg::*;

  // Entry 0 is the top, DEPTH-1 the bottom
  logic [DW-1:0] entry_r [DEPTH];

  // Whole array shifts one level per operation
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        entry_r[i] <= '0;
      end
    end else if (push) begin
      // Push: everything moves down, bottom word falls off
      entry_r[0] <= din;
      for (int i = 1; i < DEPTH; i++) begin
        entry_r[i] <= entry_r[i-1];
      end
    end else if (pull) begin
      // Pull: everything moves up, zero fills the bottom
      for (int i = 0; i < DEPTH - 1; i++) begin
        entry_r[i] <= entry_r[i+1];
      end
      entry_r[DEPTH-1] <= '0;
    end
  end

  assign top = entry_r[0];
  assign bottom = entry_r[DEPTH-1];
endmodule : cpsa_stack

/* File: src/cpsa_ea.sv */
/*
 * Effective address former for the direct addressing modes.
 * Assumes the program counter input already points past the instruction.
 */
`timescale 1ns/10ps
module cpsa_ea (
  // Instruction and base registers
  input wire logic [15:0] instr,
  input wire logic [15:0] pc,
  input wire logic [15:0] acc_two,
  input wire logic [15:0] acc_three,
  // Resulting address
  output logic [15:0] ea
);
  import cpsa_pkg::*;

  logic [1:0] mode_select_field;
  logic [7:0] offset_field;
  logic [15:0] offset_ext;

  // Split the mode field above the offset field
  assign mode_select_field = instr[CPSA_MODE_LO+1:CPSA_MODE_LO];
  assign offset_field = instr[CPSA_DISP_MSB:0];
  // Copy offset bit 7 into bits 8 to 15
  assign offset_ext = {{8{offset_field[CPSA_DISP_MSB]}}, offset_field};

  // Mode selects the base; sums wrap at 16 bits
  always_comb begin
    unique case (mode_select_field)
      CPSA_MODE_BASE: ea = {8'h00, offset_field};
      CPSA_MODE_PCREL: ea = 16'(pc + offset_ext);
      CPSA_MODE_IDX2: ea = 16'(acc_two + offset_ext);
      CPSA_MODE_IDX3: ea = 16'(acc_three + offset_ext);
    endcase
  end
endmodule : cpsa_ea

/* File: verification/cpsa_cpu_state_bench.sv */
/* Self-checking bench for the processor state block: reset state, stack,
   flags, arithmetic, program counter, address modes, peripheral path.
   Assumes the register map and command codes of cpsa_pkg. */
`timescale 1ns/10ps
module cpsa_cpu_state_bench;
  import cpsa_pkg::*;
  // Clock, reset and register port
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  // Peripheral side and enables
  logic [15:0] periph_din = 16'h0000;
  logic periph_load = 1'b0;
  logic [15:0] periph_dout;
  logic [3:0] interrupt_enable_bits;
  // Bookkeeping and scratch
  int num_errors = 0;
  int checks_done = 0;
  integer seed = 77270;
  logic [15:0] rv, a, b, c, d, p, ins, fexp;
  logic [15:0] stk [0:16];
  logic [15:0] ca [0:3] = '{16'h7FFF, 16'hFFFF, 16'h8000, 16'h8000};
  logic [15:0] cb [0:3] = '{16'h0001, 16'h0001, 16'h8000, 16'h0001};
  logic [17:0] r;
  logic [31:0] dw;
  logic sb;

  // Free-running clock, 8 ns period
  always #4 sys_clk = ~sys_clk;

  cpsa_cpu_state u_cpsa_cpu_state (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .periph_din(periph_din),
    .periph_load(periph_load),
    .periph_dout(periph_dout),
    .interrupt_enable_bits(interrupt_enable_bits)
  );

  // One-cycle write strobe, one idle cycle follows
  task automatic wr(input logic [7:0] ad, input logic [15:0] wd);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_wdata <= wd;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // One-cycle read strobe, data sampled in the following cycle
  task automatic rd(input logic [7:0] ad, output logic [15:0] q);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata;
  endtask : rd

  // Word compare, counts and reports
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Register read compared with an expected word
  task automatic rchk(input logic [7:0] ad, input logic [15:0] exp);
    logic [15:0] q;
    rd(ad, q);
    chk(q, exp);
  endtask : rchk

  // Verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  // Command word: source, destination, flag index, operation
  function automatic logic [15:0] cmdw(input logic [1:0] sr, input logic [1:0] dr,
                                       input logic [3:0] idx, input logic [3:0] op);
    return {4'h0, sr, dr, idx, op};
  endfunction : cmdw

  // Sum or difference with carry out and signed range excess
  function automatic logic [17:0] arith(input logic [15:0] x, input logic [15:0] y,
                                        input logic s);
    logic [16:0] t;
    logic [15:0] yy;
    yy = s ? ~y : y;
    t = {1'b0, x} + {1'b0, yy} + {16'h0000, s};
    return {t[16], (x[15] == yy[15]) && (t[15] != x[15]), t[15:0]};
  endfunction : arith

  // Expected effective address for the four direct modes
  function automatic logic [15:0] ea_f(input logic [15:0] i, input logic [15:0] pc,
                                       input logic [15:0] a2, input logic [15:0] a3);
    logic [15:0] off;
    off = {{8{i[7]}}, i[7:0]};
    case (i[9:8])
      2'h0: return {8'h00, i[7:0]};
      2'h1: return pc + off;
      2'h2: return a2 + off;
      default: return a3 + off;
    endcase
  endfunction : ea_f

  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    // Accumulators, counter and flags cleared after reset, unmapped read gives zero
    for (int i = 0; i < 6; i++) rchk(8'(4 * i), 16'h0000);
    rchk(8'h30, 16'h0000);
    $display("reset test done");
    // Seventeen pushes lose the first word, pulls come back in reverse
    for (int i = 0; i < 17; i++) begin
      stk[i] = 16'($random(seed));
      wr(CPSA_OFF_STACK, stk[i]);
    end
    for (int i = 16; i > 0; i--) rchk(CPSA_OFF_STACK, stk[i]);
    rchk(CPSA_OFF_STACK, 16'h0000);
    $display("stack test done");
    // Each flag tested clear, set, tested set
    fexp = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      wr(CPSA_OFF_CMD, cmdw(2'h0, 2'h0, 4'(i), CPSA_OP_FLG_TEST));
      rchk(CPSA_OFF_STATUS, 16'h0000);
      wr(CPSA_OFF_CMD, cmdw(2'h0, 2'h0, 4'(i), CPSA_OP_FLG_SET));
      fexp[i] = 1'b1;
      rchk(CPSA_OFF_FLAGS, fexp);
      wr(CPSA_OFF_CMD, cmdw(2'h0, 2'h0, 4'(i), CPSA_OP_FLG_TEST));
      rchk(CPSA_OFF_STATUS, 16'h0001);
    end
    chk({12'h000, interrupt_enable_bits}, 16'h000F);
    // Save flags, wipe them, restore, then clear one
    wr(CPSA_OFF_CMD, cmdw(2'h0, 2'h0, 4'h0, CPSA_OP_PUSH_FLG));
    wr(CPSA_OFF_FLAGS, 16'h0000);
    wr(CPSA_OFF_CMD, cmdw(2'h0, 2'h0, 4'h0, CPSA_OP_PULL_FLG));
    rchk(CPSA_OFF_FLAGS, 16'hFFFF);
    wr(CPSA_OFF_CMD, cmdw(2'h0, 2'h0, 4'h2, CPSA_OP_FLG_CLR));
    rchk(CPSA_OFF_FLAGS, 16'hFFFB);
    chk({12'h000, interrupt_enable_bits}, 16'h000B);
    $display("flag test done");
    // Add and subtract, corner values first
    for (int i = 0; i < 24; i++) begin
      rv = 16'($random(seed));
      a = (i < 4) ? ca[i] : 16'($random(seed));
      b = (i < 4) ? cb[i] : 16'($random(seed));
      sb = (i == 3) || (i > 3 && rv[0]);
      r = arith(a, b, sb);
      wr(CPSA_OFF_FLAGS, 16'h0000);
      wr(8'h04, a);
      wr(8'h08, b);
      wr(CPSA_OFF_CMD, cmdw(2'h2, 2'h1, 4'h0, sb ? CPSA_OP_SUB : CPSA_OP_ADD));
      rchk(8'h04, r[15:0]);
      rchk(CPSA_OFF_FLAGS, {1'b0, r[17:16], 13'h0000});
    end
    // Quotient sign check for all four sign pairs, carry kept
    for (int i = 0; i < 4; i++) begin
      a = {i[1], 15'($random(seed))};
      b = {i[0], 15'($random(seed))};
      wr(CPSA_OFF_FLAGS, 16'h4000);
      wr(8'h04, a);
      wr(8'h08, b);
      wr(CPSA_OFF_CMD, cmdw(2'h2, 2'h1, 4'h0, CPSA_OP_DIV_CHK));
      rchk(CPSA_OFF_FLAGS, {2'h1, a[15] ^ b[15], 13'h0000});
    end
    // Double word add: first word high, second low
    for (int i = 0; i < 4; i++) begin
      stk[i] = 16'($random(seed));
      wr(8'(4 * i), stk[i]);
    end
    dw = {stk[0], stk[1]} + {stk[2], stk[3]};
    wr(CPSA_OFF_CMD, cmdw(2'h2, 2'h0, 4'h0, CPSA_OP_DADD));
    rchk(8'h00, dw[31:16]);
    rchk(8'h04, dw[15:0]);
    $display("arithmetic test done");
    // Peripheral load lands in accumulator zero only
    @(posedge sys_clk);
    periph_din <= 16'($random(seed));
    periph_load <= 1'b1;
    @(posedge sys_clk);
    periph_load <= 1'b0;
    #1;
    chk(periph_dout, periph_din);
    wr(8'h0C, ~periph_din);
    rchk(8'h00, periph_din);
    chk(periph_dout, periph_din);
    $display("peripheral test done");
    // Branch, skip, effective address in every mode, jump
    for (int i = 0; i < 16; i++) begin
      p = 16'($random(seed));
      c = 16'($random(seed));
      d = 16'($random(seed));
      ins = 16'($random(seed));
      ins[9:8] = 2'(i);
      if (i < 8)
        ins[7:0] = i[2] ? 8'h80 : 8'h7F;
      wr(CPSA_OFF_PC, p);
      rchk(CPSA_OFF_PC, p);
      wr(CPSA_OFF_CMD, cmdw(2'h0, 2'h0, 4'h0, CPSA_OP_SKIP));
      rchk(CPSA_OFF_PC, p + 16'h0001);
      wr(8'h08, c);
      wr(8'h0C, d);
      wr(CPSA_OFF_INSTR, ins);
      rchk(CPSA_OFF_EA, ea_f(ins, p + 16'h0001, c, d));
      wr(CPSA_OFF_CMD, cmdw(2'h0, 2'h0, 4'h0, CPSA_OP_JUMP_EA));
      rchk(CPSA_OFF_PC, ea_f(ins, p + 16'h0001, c, d));
    end
    $display("address test done");
    report_and_stop();
  end
endmodule : cpsa_cpu_state_bench
